// [bench/sacr_host_model.sv]
`timescale 1ns/100ps
// host side: ideal comparator plus shift-clock frames
module sacr_host_model (
  input  wire logic [15:0] vin,      // input level as code
  input  wire logic [15:0] sar_code, // trial code
  input  wire logic        sdo,      // serial data
  input  wire logic        sdo_oe,   // data enable
  output logic             cmp,      // keep trial bit
  output logic             sck,      // shift clock
  output logic             sel       // select or chain data
);
  wire sdo_line = sdo_oe ? sdo : 1'bz; // released line never matches
  // ideal comparator, so a right result equals vin
  assign cmp = (vin >= sar_code);
  // idle: clock still, select high
  initial begin
    sck = 1'b0;
    sel = 1'b1;
  end
  // n-bit frame at 80 ns, bits taken on the falling edge
  task automatic frame(input int n, input logic casc, input logic [15:0] up, output logic [31:0] got);
    int i;
    got = 32'h00000000;
    #3;
    sel = casc ? up[15] : 1'b0;
    #40;
    got = {got[30:0], sdo_line};
    for (i = 1; i < n; i++) begin
      sck = 1'b1;
      #40;
      got = {got[30:0], sdo_line};
      sck = 1'b0;
      // next upstream bit after the edge took it
      if (casc) sel = (i < 16) ? up[15 - i] : ~sel;
      #40;
    end
    sel = casc ? ~sel : 1'b1;
  endtask
endmodule

// [bench/sacr_top_asserts.sv]
`timescale 1ns/100ps
// pin-level checks on the converter
module sacr_top_asserts
  import sacr_pkg::*;
(
  input wire logic        clk,                          // clock
  input wire logic        rst_n,                        // reset
  input wire logic        supply_ok,                    // supply
  input wire logic        conversion_start,             // start
  input wire logic        readout_select_or_cascade_in, // select
  input wire logic        chain_select,                 // mode
  input wire logic        comparator_in,                // compare
  input wire logic        sck,                          // shift
  input wire logic        sdo,                          // data
  input wire logic        sdo_oe,                       // enable
  input wire logic        busy,                         // busy
  input wire logic        powered_up,                   // power
  input wire logic        acquiring,                    // track
  input wire logic [15:0] sar_code,                     // trial
  input wire logic        reinit_done                   // ready
);
  logic [6:0] busy_cnt;      // busy cycles so far
  logic [6:0] next_busy_cnt; // zero when idle
  // count busy cycles
  always_comb begin
    next_busy_cnt = busy ? busy_cnt + 7'h01 : 7'h00;
  end
  // may wrap only on a run far too long, flagged first by the bound
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_cnt <= 7'h00;
    end else begin
      busy_cnt <= next_busy_cnt;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_busy_length: assert property ($fell(busy) |-> busy_cnt == 7'h30) else $error("busy length");
  a_busy_bound: assert property (busy |-> busy_cnt < 7'h41) else $error("conversion too long");
  a_start_busy: assert property ($rose(conversion_start) && !busy && reinit_done |-> ##[1:6] busy)
    else $error("start not taken");
  a_power_track: assert property (powered_up == busy && acquiring == !busy)
    else $error("power state");
  a_first_trial: assert property ($rose(busy) |-> sar_code == 16'h8000) else $error("first trial");
  // pin stages restart at zero after reset, so the first cycle after release is left out
  a_sdo_off: assert property ((!chain_select && readout_select_or_cascade_in && $past(rst_n)) [*3] |-> !sdo_oe)
    else $error("sdo not released");
  a_sdo_on: assert property ((!chain_select && !readout_select_or_cascade_in && $past(rst_n)) [*3] |-> sdo_oe)
    else $error("sdo not driven");
  a_chain_on: assert property (chain_select [*3] |-> sdo_oe) else $error("chain sdo off");
  a_result_held: assert property (!busy && !$past(busy) && !sck && !$past(sck) && supply_ok
    && $past(supply_ok, 3) |-> $stable(sdo)) else $error("result lost");
  a_reinit_clear: assert property ((!supply_ok) [*4] |-> !reinit_done) else $error("reinit kept");
  c_done: cover property ($fell(busy));
  c_chain: cover property (chain_select && $rose(sck));
  c_drop: cover property ($fell(reinit_done));
endmodule

// [bench/sar_adc_convert_serial_readout_test.sv]
`timescale 1ns/100ps
module sar_adc_convert_serial_readout_test;
  logic        clk;              // clock
  logic        rst_n;            // reset
  logic        supply_ok;        // supply good
  logic        conversion_start; // start pin
  logic        chain_select;     // cascade
  logic [15:0] vin;              // input level
  logic        sck;              // shift clock
  logic        sel;              // select
  logic        cmp;              // comparator
  logic        sdo;              // data
  logic        sdo_oe;           // enable
  logic        busy;             // converting
  logic        powered_up;       // core on
  logic        acquiring;        // tracking
  logic [15:0] sar_code;         // trial
  logic        reinit_done;      // settled
  logic [31:0] got;              // frame bits
  int          error_cnt;        // mismatches
  int          total_checks;     // checks
  sacr_top i_dut (.clk(clk), .rst_n(rst_n), .supply_ok(supply_ok), .conversion_start(conversion_start),
    .readout_select_or_cascade_in(sel), .chain_select(chain_select), .comparator_in(cmp), .sck(sck),
    .sdo(sdo), .sdo_oe(sdo_oe), .busy(busy), .powered_up(powered_up), .acquiring(acquiring),
    .sar_code(sar_code), .reinit_done(reinit_done));
  sacr_host_model i_host (.vin(vin), .sar_code(sar_code), .sdo(sdo), .sdo_oe(sdo_oe), .cmp(cmp),
    .sck(sck), .sel(sel));
  // 125 MHz
  always #4 clk = ~clk;
  // judge one value
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] act);
    total_checks++;
    if (act !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, act);
    end
  endtask
  // counts, verdict, end
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // bounded wait on busy (which 0) or reinit_done (which 1)
  task automatic wait_for(input logic which, input logic lvl, input int lim);
    int n;
    for (n = 0; n < lim; n++) begin
      @(posedge clk);
      #1;
      if ((which ? reinit_done : busy) === lvl) return;
    end
    check("wait", {31'h0, lvl}, {31'h0, ~lvl});
    final_report();
  endtask
  // one conversion, optionally a stray start pulse midway
  task automatic convert(input logic [15:0] v, input logic retrig);
    int n;
    n = 1;
    @(posedge clk);
    vin <= v;
    conversion_start <= 1'b1;
    wait_for(1'b0, 1'b1, 10);
    check("powered_up", 32'h1, {31'h0, powered_up});
    // n counts edges with busy seen high; the first is already behind us
    while (n < 100) begin
      @(posedge clk);
      conversion_start <= retrig && n >= 10 && n < 14;
      #1;
      if (busy !== 1'b1) break;
      n++;
    end
    check("busy cycles", 32'h00000030, n);
    check("acquiring", 32'h1, {31'h0, acquiring});
    check("powered_down", 32'h0, {31'h0, powered_up});
    repeat (58) @(posedge clk);
  endtask
  // normal mode, range ends and middle, one with a stray start
  task automatic t_normal;
    logic [15:0] codes [5];
    int k;
    codes = '{16'hffff, 16'h0000, 16'h8000, 16'h7fff, 16'ha5c3};
    for (k = 0; k < 5; k++) begin
      convert(codes[k], k == 4);
      if (k == 2) repeat (200) @(posedge clk);
      i_host.frame(16, 1'b0, 16'h0000, got);
      check("normal word", {16'h0, codes[k]}, {16'h0, got[15:0]});
      repeat (4) @(posedge clk);
      #1;
      check("sdo_oe idle", 32'h0, {31'h0, sdo_oe});
    end
    $display("test normal done");
  endtask
  // cascade: own word then upstream word
  task automatic t_cascade;
    @(posedge clk);
    chain_select <= 1'b1;
    convert(16'h3c96, 1'b0);
    check("sdo_oe chain", 32'h1, {31'h0, sdo_oe});
    i_host.frame(32, 1'b1, 16'hc35a, got);
    check("chain frame", 32'h3c96c35a, got);
    @(posedge clk);
    chain_select <= 1'b0;
    $display("test cascade done");
  endtask
  // supply drop, settling time, then a good conversion
  task automatic t_supply;
    @(posedge clk);
    supply_ok <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
    check("reinit low", 32'h0, {31'h0, reinit_done});
    supply_ok <= 1'b1;
    repeat (2400) @(posedge clk);
    #1;
    check("reinit early", 32'h0, {31'h0, reinit_done});
    wait_for(1'b1, 1'b1, 200);
    convert(16'h1234, 1'b0);
    i_host.frame(16, 1'b0, 16'h0000, got);
    check("after supply", 32'h1234, {16'h0, got[15:0]});
    $display("test supply done");
  endtask
  // reset, settle, scenarios
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    supply_ok = 1'b1;
    conversion_start = 1'b0;
    chain_select = 1'b0;
    vin = 16'h0000;
    error_cnt = 0;
    total_checks = 0;
    repeat (4) @(posedge clk);
    check("reset busy", 32'h0, {31'h0, busy});
    rst_n <= 1'b1;
    wait_for(1'b1, 1'b1, 3000);
    $display("test reset done");
    t_normal();
    t_cascade();
    t_supply();
    final_report();
  end
endmodule
bind sacr_top sacr_top_asserts i_chk (.clk(clk), .rst_n(rst_n), .supply_ok(supply_ok),
  .conversion_start(conversion_start), .readout_select_or_cascade_in(readout_select_or_cascade_in),
  .chain_select(chain_select), .comparator_in(comparator_in), .sck(sck), .sdo(sdo), .sdo_oe(sdo_oe),
  .busy(busy), .powered_up(powered_up), .acquiring(acquiring), .sar_code(sar_code), .reinit_done(reinit_done));

// [design/sacr_defines.svh]
`ifndef SACR_DEFINES_SVH
`define SACR_DEFINES_SVH

// result width, straight binary
`define SACR_BITS          16
`define SACR_MSB           15
`define SACR_IDX_W         4
`define SACR_TOP_IDX       4'hf
`define SACR_ZERO_IDX      4'h0
`define SACR_WORD_ZERO     16'h0000
`define SACR_ONE_HOT_LSB   16'h0001
`define SACR_MID_CODE      16'h8000

// local clock
`define SACR_CLK_PERIOD_NS 8

// longest conversion time, rounded down to whole cycles
`define SACR_CONV_MAX_NS   527
`define SACR_CONV_MAX_CYC  (`SACR_CONV_MAX_NS / `SACR_CLK_PERIOD_NS)
// cycles from the start pin to the first trial (two sync stages plus the sequencer state register)
`define SACR_START_LAT_CYC 3
// cycles spent on each trial bit
`define SACR_CYC_PER_BIT   ((`SACR_CONV_MAX_CYC - `SACR_START_LAT_CYC) / `SACR_BITS)
`define SACR_STEP_W        2
`define SACR_STEP_LAST     (`SACR_STEP_W'(`SACR_CYC_PER_BIT - 1))
`define SACR_STEP_ZERO     2'h0
`define SACR_STEP_ONE      2'h1

// settling time after a supply reset, rounded up
`define SACR_REINIT_NS     20000
`define SACR_REINIT_CYC    ((`SACR_REINIT_NS + `SACR_CLK_PERIOD_NS - 1) / `SACR_CLK_PERIOD_NS)
`define SACR_REINIT_W      12
`define SACR_REINIT_LAST   (`SACR_REINIT_W'(`SACR_REINIT_CYC - 1))
`define SACR_REINIT_ZERO   12'h000
`define SACR_REINIT_ONE    12'h001

`endif

// [design/sacr_if.sv]
`timescale 1ns/100ps
// carries the result word and handover toggles between the clk and sck domains
interface sacr_if;
  logic [15:0] word;      // last result, held stable between conversions while the supply is good
  logic        load_tgl;  // flips when a new word is ready (clk domain)
  logic        take_tgl;  // follows load_tgl once the shifter took the word (sck domain)
  logic        shift_msb; // top bit of the shift register (sck domain)

  modport ctl (output word, output load_tgl, input take_tgl, input shift_msb);
  modport lnk (input word, input load_tgl, output take_tgl, output shift_msb);
endinterface

// [design/sacr_pkg.sv]
package sacr_pkg;
  // converter sequencing states
  typedef enum logic [0:0] {
    SACR_IDLE = 1'b0,  // powered down, acquiring
    SACR_CONV = 1'b1   // conversion running
  } sacr_state_t;
endpackage

// [design/sacr_shifter.sv]
`timescale 1ns/100ps
`include "sacr_defines.svh"
// output shift register, clocked by the host shift clock
module sacr_shifter
  import sacr_pkg::*;
(
  input  wire logic sck,    // host shift clock
  input  wire logic rst_n,  // async reset, active low
  input  wire logic sdi,    // upstream data in cascade mode
  sacr_if.lnk       lnk     // word handover from the control domain
);

  logic [`SACR_MSB:0] shreg;      // shift register
  logic [`SACR_MSB:0] next_shreg; // next shift value
  logic               take;       // taken toggle
  logic               next_take;  // next taken toggle
  logic               fresh;      // an untaken word waits

  // the word is stable for the whole acquisition while the supply is good, so sampling the toggle here is safe;
  // the host must not clock during the end of a conversion
  assign fresh = lnk.load_tgl ^ take;

  // shift one bit per rising edge; a fresh word is loaded and shifted at once
  always_comb begin
    next_take = take;
    if (fresh) begin
      next_shreg = {lnk.word[`SACR_MSB-1:0], sdi};
      next_take  = lnk.load_tgl;
    end else begin
      next_shreg = {shreg[`SACR_MSB-1:0], sdi};
    end
  end

  // register only
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      shreg <= `SACR_WORD_ZERO;
      take  <= 1'b0;
    end else begin
      shreg <= next_shreg;
      take  <= next_take;
    end
  end

  assign lnk.take_tgl  = take;
  assign lnk.shift_msb = shreg[`SACR_MSB];

endmodule

// [design/sacr_top.sv]
`timescale 1ns/100ps
`include "sacr_defines.svh"
module sacr_top
  import sacr_pkg::*;
(
  input  wire logic        clk,                          // 125 MHz internal clock
  input  wire logic        rst_n,                        // async reset, active low
  input  wire logic        supply_ok,                    // supply monitor, low below 1V
  input  wire logic        conversion_start,             // start pin, rising edge starts
  input  wire logic        readout_select_or_cascade_in, // output select, or cascade data
  input  wire logic        chain_select,                 // high selects cascade mode
  input  wire logic        comparator_in,                // analog comparator, high keeps trial bit
  input  wire logic        sck,                          // host shift clock
  output logic             sdo,                          // serial data out
  output logic             sdo_oe,                       // serial output enable, high drives
  output logic             busy,                         // high while converting
  output logic             powered_up,                   // analog core powered
  output logic             acquiring,                    // input sampling network tracking
  output logic [15:0]      sar_code,                     // trial code to the capacitor array
  output logic             reinit_done                   // settling after supply reset over
);

  // the shift domain reads the word and the load toggle with no synchroniser:
  // both move only at the end of a conversion (the word also clears on a supply drop), while the host keeps sck still,
  // and a synchroniser would cost the top bit its place before the first edge
  sacr_if link_if ();  // word handover to the shift domain

  // ---------------------------------------------------------------
  // input synchronisers, two stages each
  // ---------------------------------------------------------------
  logic [4:0] sync_a;       // first stage, read only by the second
  logic [4:0] sync_b;       // second stage, usable
  logic [4:0] next_sync_a;  // next first stage
  logic [4:0] next_sync_b;  // next second stage
  logic       start_q;      // previous synced start, for edge detect
  logic       next_start_q; // next previous start

  logic supply_s; // synced supply monitor
  logic start_s;  // synced start pin
  logic sel_s;    // synced readout select
  logic chain_s;  // synced mode select
  logic cmp_s;    // synced comparator

  // the comparator is treated like a pin: it settles with no regard to clk
  // pin samples go straight into the first stage
  always_comb begin
    next_sync_a  = {comparator_in, chain_select, readout_select_or_cascade_in,
                    conversion_start, supply_ok};
    next_sync_b  = sync_a;
    next_start_q = start_s;
  end

  // register only; supply stage resets low so logic starts held
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a  <= 5'h00;
      sync_b  <= 5'h00;
      start_q <= 1'b0;
    end else begin
      sync_a  <= next_sync_a;
      sync_b  <= next_sync_b;
      start_q <= next_start_q;
    end
  end

  assign supply_s = sync_b[0];
  assign start_s  = sync_b[1];
  assign sel_s    = sync_b[2];
  assign chain_s  = sync_b[3];
  assign cmp_s    = sync_b[4];

  // start_q resets low like the idle pin, so no false edge follows reset
  logic start_rise; // one-cycle start edge
  assign start_rise = start_s & ~start_q;

  // ---------------------------------------------------------------
  // reinitialisation timer after a supply reset
  // ---------------------------------------------------------------
  logic [`SACR_REINIT_W-1:0] reinit_cnt;      // cycles since supply returned
  logic [`SACR_REINIT_W-1:0] next_reinit_cnt; // next count
  logic                      settled;         // timer expired
  logic                      next_settled;    // next expired flag

  // the supply monitor pin stands in for the on-chip power-on detector;
  // a low level clears the sequencer and the result like a synchronous reset
  // restart whenever the supply drops; only reports, the host owns the wait
  always_comb begin
    next_reinit_cnt = reinit_cnt;
    next_settled    = settled;
    if (!supply_s) begin
      next_reinit_cnt = `SACR_REINIT_ZERO;
      next_settled    = 1'b0;
    end else if (!settled) begin
      if (reinit_cnt == `SACR_REINIT_LAST) begin
        next_settled = 1'b1;
      end else begin
        next_reinit_cnt = reinit_cnt + `SACR_REINIT_ONE;
      end
    end
  end

  // register only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reinit_cnt <= `SACR_REINIT_ZERO;
      settled    <= 1'b0;
    end else begin
      reinit_cnt <= next_reinit_cnt;
      settled    <= next_settled;
    end
  end

  // ---------------------------------------------------------------
  // conversion sequencer and successive approximation
  // ---------------------------------------------------------------
  sacr_state_t           state;        // sequencer state
  sacr_state_t           next_state;   // next state
  logic [`SACR_IDX_W-1:0]  bit_idx;      // bit under trial
  logic [`SACR_IDX_W-1:0]  next_bit_idx; // next bit under trial
  logic [`SACR_STEP_W-1:0] step;         // settle cycle within a bit
  logic [`SACR_STEP_W-1:0] next_step;    // next settle cycle
  logic [`SACR_MSB:0]      dac;          // trial code
  logic [`SACR_MSB:0]      next_dac;     // next trial code
  logic [`SACR_MSB:0]      mask;         // one-hot of the bit under trial
  logic [`SACR_MSB:0]      kept;         // trial code after the decision
  logic                    finish;       // last decision this cycle

  // the trial starts at mid scale and walks one bit down every three cycles,
  // sixteen bits in 48 cycles, well inside the conversion budget
  assign mask   = `SACR_ONE_HOT_LSB << bit_idx;
  // comparator high means input sits above the trial, so the bit stays
  assign kept   = cmp_s ? dac : (dac & ~mask);
  assign finish = (state == SACR_CONV) && (step == `SACR_STEP_LAST) &&
                  (bit_idx == `SACR_ZERO_IDX);

  // three cycles per bit keep the whole run inside the longest conversion time;
  // the comparator reaches cmp_s two cycles late, so the decision uses the last step
  always_comb begin
    next_state   = state;
    next_bit_idx = bit_idx;
    next_step    = step;
    next_dac     = dac;
    case (state)
      SACR_IDLE: begin
        // powered down, old result stays in the word register
        if (start_rise && supply_s) begin
          next_state   = SACR_CONV;
          next_bit_idx = `SACR_TOP_IDX;
          next_step    = `SACR_STEP_ZERO;
          next_dac     = `SACR_MID_CODE;
        end
      end
      SACR_CONV: begin
        // start edges are not looked at here, so nothing restarts a run
        if (step == `SACR_STEP_LAST) begin
          next_step = `SACR_STEP_ZERO;
          if (bit_idx == `SACR_ZERO_IDX) begin
            next_state = SACR_IDLE;
            next_dac   = `SACR_WORD_ZERO;
          end else begin
            next_bit_idx = bit_idx - `SACR_IDX_W'(1);
            next_dac     = kept | (mask >> 1);
          end
        end else begin
          next_step = step + `SACR_STEP_ONE;
        end
      end
      default: begin
        next_state = SACR_IDLE;
      end
    endcase
    if (!supply_s) begin
      next_state = SACR_IDLE;
      next_dac   = `SACR_WORD_ZERO;
    end
  end

  // register only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state   <= SACR_IDLE;
      bit_idx <= `SACR_TOP_IDX;
      step    <= `SACR_STEP_ZERO;
      dac     <= `SACR_WORD_ZERO;
    end else begin
      state   <= next_state;
      bit_idx <= next_bit_idx;
      step    <= next_step;
      dac     <= next_dac;
    end
  end

  // ---------------------------------------------------------------
  // result word and handover toggle
  // ---------------------------------------------------------------
  logic [`SACR_MSB:0] word;          // last finished result
  logic [`SACR_MSB:0] next_word;     // next result
  logic               load_tgl;      // flips per new result
  logic               next_load_tgl; // next toggle
  logic               busy_q;        // registered busy
  logic               next_busy_q;   // next busy

  // the word changes only at completion or on a supply drop, so it is stable while powered down with the supply good
  always_comb begin
    next_word     = word;
    next_load_tgl = load_tgl;
    next_busy_q   = (next_state == SACR_CONV);
    if (finish && supply_s) begin
      next_word     = kept;
      next_load_tgl = ~load_tgl;
    end else if (!supply_s) begin
      next_word = `SACR_WORD_ZERO;
    end
  end

  // register only; word and busy fall on the same edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word     <= `SACR_WORD_ZERO;
      load_tgl <= 1'b0;
      busy_q   <= 1'b0;
    end else begin
      word     <= next_word;
      load_tgl <= next_load_tgl;
      busy_q   <= next_busy_q;
    end
  end

  assign link_if.word     = word;
  assign link_if.load_tgl = load_tgl;

  // ---------------------------------------------------------------
  // shift domain
  // ---------------------------------------------------------------
  sacr_shifter u_shifter (
    .sck   (sck),
    .rst_n (rst_n),
    .sdi   (readout_select_or_cascade_in),
    .lnk   (link_if.lnk)
  );

  // ---------------------------------------------------------------
  // serial output and enable
  // ---------------------------------------------------------------
  logic fresh; // new word not yet touched by a shift edge

  // limitation: fresh mixes a clk-domain and an sck-domain toggle, so a shift
  // edge right at the end of a conversion can glitch sdo for one clk period;
  // the host is expected to read only after busy falls
  // both toggles are flops; they differ only between completion and first edge
  assign fresh = load_tgl ^ link_if.take_tgl;

  // before the first edge the word's top bit shows directly
  always_comb begin
    if (fresh) begin
      sdo = word[`SACR_MSB];
    end else begin
      sdo = link_if.shift_msb;
    end
  end

  // the select passes the same two stages as the other pins, so the enable
  // trails the pin by two clk cycles
  // cascade keeps the pin driven; normal mode follows the select
  always_comb begin
    if (chain_s) begin
      sdo_oe = 1'b1;
    end else begin
      sdo_oe = ~sel_s;
    end
  end

  // power and acquisition follow busy: the core is up only while converting
  assign busy        = busy_q;
  assign powered_up  = busy_q;
  assign acquiring   = ~busy_q;
  assign sar_code    = dac;
  assign reinit_done = settled;

endmodule
